// >>> dv/data_bus_model.sv
// Behavioural model of the data bus that answers loads and ignores store data.
// Assumes load data is wanted in the same cycle as the request.
`timescale 1ns/1ps
`default_nettype none

module data_bus_model (
  input wire logic clock,
  input wire data_move_pkg::mem_req_s mem_req,
  output logic [31:0] mem_rdata
);
  // Last value shown, used to scramble the idle bus
  logic [31:0] last_ff = 32'h0000_0000;

  // ****************************************
  // Read answer
  // ****************************************
  // Full pattern word, upper bits junk for byte and word reads
  always_comb begin
    if (mem_req.req && !mem_req.wr) begin
      mem_rdata = (mem_req.addr * 32'h9E37_79B1) ^ 32'h5A5A_C3C3;
    end else begin
      mem_rdata = ~last_ff;
    end
  end

  // Remember bus value
  always_ff @(posedge clock) begin
    last_ff <= mem_rdata;
  end
endmodule
`default_nettype wire

// >>> dv/data_move_instruction_unit_tb.sv
// Self-checking bench for the data-move unit with random register values.
// Assumes the data bus model answers with its address-hash pattern.
`timescale 1ns/1ps
`default_nettype none

module data_move_instruction_unit_tb;
  // Expected outcome of one instruction
  typedef struct packed {
    logic err;
    logic [31:0] ea;
    data_move_pkg::rf_wr_s w;
    logic [31:0] pc;
  } exp_s;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  data_move_pkg::issue_s issue = '0;
  data_move_pkg::rf_rd_s rf_rd = '0;
  logic [3:0] src_num;
  logic [3:0] dst_num;
  data_move_pkg::mem_req_s mem_req;
  data_move_pkg::rf_wr_s rf_wr;
  logic [31:0] mem_rdata;
  logic [31:0] next_pc;
  logic [31:0] error_addr;
  logic done;
  logic addr_error;
  int failures = 0;
  int num_checks = 0;
  exp_s notes[$];
  // Opcode templates, register fields zero except in 16'hC400
  logic [15:0] tpl [24] = '{16'h6003, 16'h6000, 16'h6001, 16'h6002, 16'h6004, 16'h6005,
    16'h6006, 16'h2000, 16'h2001, 16'h2002, 16'h2004, 16'h2005, 16'h2006, 16'h0004,
    16'h0005, 16'h0006, 16'h000C, 16'h000D, 16'h000E, 16'h9000, 16'hD000, 16'hE000,
    16'h6007, 16'hC400};

  data_move_instruction_unit dut (.clock(clock), .sys_rst(sys_rst), .issue(issue),
    .src_num(src_num), .dst_num(dst_num), .rf_rd(rf_rd), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .rf_wr(rf_wr), .next_pc(next_pc), .done(done),
    .addr_error(addr_error), .error_addr(error_addr));
  data_bus_model mem (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // Clock, 10 ns period
  initial begin
    forever #5 clock = ~clock;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] sext(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      2'h0: return {{24{v[7]}}, v[7:0]};
      2'h1: return {{16{v[15]}}, v[15:0]};
      default: return v;
    endcase
  endfunction

  task automatic mismatch(input string msg);
    failures++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compare the combinational bus request
  task automatic cmp_req(input logic [15:0] op, input logic xr, input logic st,
                         input logic [1:0] sz, input logic [31:0] a, input logic [31:0] wd);
    num_checks++;
    if (src_num !== op[7:4] || dst_num !== op[11:8] || mem_req.req !== xr ||
        (xr && (mem_req.wr !== st || mem_req.addr !== a ||
        mem_req.size !== data_move_pkg::size_e'(sz) || (st && mem_req.wdata !== wd))))
      mismatch("memory request");
  endtask

  // Compare registered results against one note
  task automatic cmp_res(input exp_s e);
    num_checks++;
    if (addr_error !== e.err || rf_wr.we_a !== e.w.we_a || rf_wr.we_b !== e.w.we_b ||
        (e.err && error_addr !== e.ea) || (!e.err && (done !== 1'b1 || next_pc !== e.pc)) ||
        (e.w.we_a && (rf_wr.num_a !== e.w.num_a || rf_wr.val_a !== e.w.val_a)) ||
        (e.w.we_b && (rf_wr.num_b !== e.w.num_b || rf_wr.val_b !== e.w.val_b)))
      mismatch("register result");
  endtask

  // ****************************************
  // Driver and predictor
  // ****************************************
  task automatic run_op(input logic [15:0] op);
    logic [3:0] g;
    logic [3:0] mi;
    logic [1:0] sz;
    logic ld;
    logic st;
    logic ok;
    logic [31:0] a;
    logic [31:0] base;
    logic [31:0] lane;
    exp_s e;
    @(negedge clock);
    issue.valid = 1'b1;
    issue.opcode = op;
    issue.pc = $urandom & 32'hFFFF_FFFE;
    issue.delay_slot = 1'($urandom % 2);
    issue.branch_pc = $urandom & 32'hFFFF_FFFE;
    rf_rd.src_val = $urandom;
    rf_rd.dst_val = $urandom;
    rf_rd.idx_val = $urandom;
    g = op[15:12];
    mi = op[3:0];
    sz = mi[1:0];
    e = '0;
    e.pc = issue.pc + 32'h2;
    ld = 1'b0;
    st = 1'b0;
    ok = 1'b1;
    a = 32'h0;
    base = issue.delay_slot ? issue.branch_pc + 32'h2 : issue.pc + 32'h4;
    case (g)
      4'h6: begin
        ld = mi inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
        ok = ld || mi == 4'h3;
        a = rf_rd.src_val;
      end
      4'h2: begin
        st = mi inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
        ok = st;
        a = mi[2] ? rf_rd.dst_val - (32'h1 << sz) : rf_rd.dst_val;
      end
      4'h0: begin
        st = mi inside {4'h4, 4'h5, 4'h6};
        ld = mi inside {4'hC, 4'hD, 4'hE};
        ok = st || ld;
        a = (st ? rf_rd.dst_val : rf_rd.src_val) + rf_rd.idx_val;
      end
      4'h9: begin
        ld = 1'b1;
        sz = 2'h1;
        a = base + 32'({op[7:0], 1'b0});
      end
      4'hD: begin
        ld = 1'b1;
        sz = 2'h2;
        a = (base & 32'hFFFF_FFFC) + 32'({op[7:0], 2'b00});
      end
      4'hE: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    e.err = (ld || st) && ((sz == 2'h1 && a[0]) || (sz == 2'h2 && a[1:0] != 2'h0));
    e.ea = a;
    e.w.we_a = ok && !st && !e.err;
    e.w.num_a = op[11:8];
    e.w.val_a = (g == 4'hE) ? sext({24'h0, op[7:0]}, 2'h0) :
                ld ? sext((a * 32'h9E37_79B1) ^ 32'h5A5A_C3C3, sz) : rf_rd.src_val;
    e.w.we_b = !e.err && mi[2] && ((g == 4'h6 && op[11:8] != op[7:4]) || (g == 4'h2));
    e.w.num_b = (g == 4'h6) ? op[7:4] : op[11:8];
    e.w.val_b = (g == 4'h6) ? a + (32'h1 << sz) : a;
    if (ok) notes.push_back(e);
    // Low-order lanes of the source that a store carries
    lane = (sz == 2'h0) ? 32'h0000_00FF : (sz == 2'h1) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    #1;
    cmp_req(op, (ld || st) && !e.err, st, sz, a, rf_rd.src_val & lane);
  endtask

  // ****************************************
  // Result monitor
  // ****************************************
  always @(posedge clock) begin
    #1;
    if (!sys_rst && (done === 1'b1 || addr_error === 1'b1 || rf_wr.we_a === 1'b1 ||
        rf_wr.we_b === 1'b1)) begin
      if (notes.size() == 0) mismatch("result without instruction");
      else cmp_res(notes.pop_front());
    end
  end

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    int r;
    logic [15:0] t;
    r = $urandom(32'h8C53);
    repeat (3) @(posedge clock);
    #1;
    num_checks++;
    if (done !== 1'b0 || addr_error !== 1'b0 || rf_wr !== '0 || next_pc !== 32'h0)
      mismatch("reset outputs");
    @(negedge clock);
    sys_rst = 1'b0;
    // Post-increment with equal registers
    run_op(16'h6336);
    foreach (tpl[i]) run_op(tpl[i] | 16'h0210);
    for (int k = 0; k < 400; k++) begin
      t = tpl[$urandom % 24];
      r = $urandom;
      if (t[15:12] inside {4'h9, 4'hD, 4'hE}) run_op({t[15:12], r[11:0]});
      else run_op({t[15:12], r[11:4], t[3:0]});
      if (r[31:30] == 2'h0) begin
        @(negedge clock);
        issue.valid = 1'b0;
      end
    end
    @(negedge clock);
    issue.valid = 1'b0;
    repeat (3) @(posedge clock);
    num_checks++;
    if (notes.size() != 0) mismatch("instructions left unanswered");
    report_and_stop();
  end

  initial begin
    #50000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> rtl/data_move_instruction_unit.sv
// Decode and execute logic for register moves, loads, stores and literals.
// Assumes the register file reads combinationally from the numbers given
// and the memory returns load data in the same cycle as the request.
`timescale 1ns/1ps
`default_nettype none

module data_move_instruction_unit (
  input wire logic clock,
  input wire logic sys_rst,
  input wire data_move_pkg::issue_s issue,
  output logic [3:0] src_num,
  output logic [3:0] dst_num,
  input wire data_move_pkg::rf_rd_s rf_rd,
  output data_move_pkg::mem_req_s mem_req,
  input wire logic [31:0] mem_rdata,
  output data_move_pkg::rf_wr_s rf_wr,
  output logic [31:0] next_pc,
  output logic done,
  output logic addr_error,
  output logic [31:0] error_addr
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    data_move_pkg::rf_wr_s wr;
    logic [31:0] npc;
    logic done;
    logic err;
    logic [31:0] eaddr;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  // Decode signals
  data_move_pkg::kind_e kind;
  data_move_pkg::size_e size;
  logic [31:0] size_bytes;
  logic [31:0] addr;
  logic [31:0] lit_pc;
  logic [31:0] load_ext;
  logic mode_predec;
  logic mode_postinc;
  logic misaligned;
  logic [3:0] grp;
  logic [3:0] minor;

  assign grp = issue.opcode[15:12];
  assign minor = issue.opcode[3:0];
  assign dst_num = issue.opcode[11:8];
  assign src_num = issue.opcode[7:4];

  // ****************************************
  // Decode
  // ****************************************
  // Classify opcode, pick access size and addressing mode
  always_comb begin
    kind = data_move_pkg::K_NONE;
    size = data_move_pkg::SZ_L;
    mode_predec = 1'b0;
    mode_postinc = 1'b0;
    if (issue.valid) begin
      kind = data_move_pkg::K_ILL;
      unique case (grp)
        data_move_pkg::OP_GRP_STORE: begin
          // RULE_02 store sizes
          if (minor[3] == 1'b0 && minor[1:0] != 2'h3) begin
            kind = data_move_pkg::K_STORE;
            size = data_move_pkg::size_e'(minor[1:0]);
            mode_predec = minor[2];
          end
        end
        data_move_pkg::OP_GRP_LOAD: begin
          if (minor == data_move_pkg::MINOR_COPY) begin
            kind = data_move_pkg::K_COPY;
          end else if (minor[3] == 1'b0 && minor[1:0] != 2'h3) begin
            kind = data_move_pkg::K_LOAD;
            size = data_move_pkg::size_e'(minor[1:0]);
            mode_postinc = minor[2];
          end
        end
        data_move_pkg::OP_GRP_IDX: begin
          // Minors 4/5/6 store, C/D/E load; low two bits give the size directly
          if (minor[2] && minor[1:0] != 2'h3) begin
            kind = minor[3] ? data_move_pkg::K_LOAD : data_move_pkg::K_STORE;
            size = data_move_pkg::size_e'(minor[1:0]);
          end
        end
        data_move_pkg::OP_GRP_LITW: begin
          kind = data_move_pkg::K_LITW;
          size = data_move_pkg::SZ_W;
        end
        data_move_pkg::OP_GRP_LITL: begin
          kind = data_move_pkg::K_LITL;
        end
        data_move_pkg::OP_GRP_IMM: begin
          kind = data_move_pkg::K_IMM;
        end
        default: begin
          kind = data_move_pkg::K_ILL;
        end
      endcase
    end
  end

  // Access size in bytes
  always_comb begin
    unique case (size)
      data_move_pkg::SZ_B: size_bytes = data_move_pkg::SIZE_BYTE;
      data_move_pkg::SZ_W: size_bytes = data_move_pkg::SIZE_WORD;
      default: size_bytes = data_move_pkg::SIZE_LONG;
    endcase
  end

  // ****************************************
  // Address formation
  // ****************************************
  // Literal base PC: second instruction after, or branch plus two in a slot
  always_comb begin
    // RULE_13 second instruction ahead
    lit_pc = issue.pc + data_move_pkg::LIT_PC_AHEAD;
    // RULE_14 delay slot base
    if (issue.delay_slot) begin
      lit_pc = issue.branch_pc + data_move_pkg::INSN_STEP;
    end
  end

  // Effective address per mode
  always_comb begin
    addr = rf_rd.dst_val;
    if (kind == data_move_pkg::K_STORE) begin
      if (grp == data_move_pkg::OP_GRP_IDX) begin
        // RULE_06 indexed store address
        addr = rf_rd.dst_val + rf_rd.idx_val;
      end else if (mode_predec) begin
        // RULE_04 decremented address
        addr = rf_rd.dst_val - size_bytes;
      end else begin
        // RULE_09 plain indirect store
        addr = rf_rd.dst_val;
      end
    end else if (kind == data_move_pkg::K_LOAD) begin
      if (grp == data_move_pkg::OP_GRP_IDX) begin
        // RULE_07 indexed load address
        addr = rf_rd.src_val + rf_rd.idx_val;
      end else begin
        // RULE_08 indirect load address
        addr = rf_rd.src_val;
      end
    end else if (kind == data_move_pkg::K_LITW) begin
      // RULE_11 RULE_15 unsigned displacement, max 510
      addr = lit_pc + {23'h000000, issue.opcode[7:0], 1'b0};
    end else if (kind == data_move_pkg::K_LITL) begin
      // RULE_12 RULE_15 quadrupled, PC aligned, max 1020
      addr = (lit_pc & data_move_pkg::LONG_ALIGN_MASK)
           + {22'h000000, issue.opcode[7:0], 2'h0};
    end
  end

  // RULE_18 alignment check
  always_comb begin
    unique case (size)
      data_move_pkg::SZ_W: misaligned = addr[0];
      data_move_pkg::SZ_L: misaligned = addr[1] | addr[0];
      default: misaligned = 1'b0;
    endcase
  end

  // ****************************************
  // Memory request
  // ****************************************
  logic mem_kind;
  assign mem_kind = (kind == data_move_pkg::K_STORE) || (kind == data_move_pkg::K_LOAD)
                  || (kind == data_move_pkg::K_LITW) || (kind == data_move_pkg::K_LITL);

  // Bus request, suppressed on an address error
  always_comb begin
    mem_req.req = mem_kind && !misaligned;
    mem_req.wr = (kind == data_move_pkg::K_STORE);
    mem_req.size = size;
    mem_req.addr = addr;
    // RULE_02 low-order part of source
    unique case (size)
      data_move_pkg::SZ_B: mem_req.wdata = {24'h000000, rf_rd.src_val[7:0]};
      data_move_pkg::SZ_W: mem_req.wdata = {16'h0000, rf_rd.src_val[15:0]};
      default: mem_req.wdata = rf_rd.src_val;
    endcase
  end

  // RULE_03 sign extension of loaded data
  always_comb begin
    unique case (size)
      data_move_pkg::SZ_B: load_ext = {{24{mem_rdata[7]}}, mem_rdata[7:0]};
      data_move_pkg::SZ_W: load_ext = {{16{mem_rdata[15]}}, mem_rdata[15:0]};
      default: load_ext = mem_rdata;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  // Fill register writes, PC step and error outcome
  always_comb begin
    nxt_st = '0;
    if (kind != data_move_pkg::K_NONE) begin
      nxt_st.done = 1'b1;
      // RULE_17 one cycle, PC plus two
      nxt_st.npc = issue.pc + data_move_pkg::INSN_STEP;
      nxt_st.wr.num_a = dst_num;
      nxt_st.wr.num_b = (kind == data_move_pkg::K_STORE) ? dst_num : src_num;
      if (mem_kind && misaligned) begin
        // RULE_18 no register change on error
        nxt_st.err = 1'b1;
        nxt_st.eaddr = addr;
      end else begin
        unique case (kind)
          data_move_pkg::K_COPY: begin
            // RULE_01 full copy
            nxt_st.wr.we_a = 1'b1;
            nxt_st.wr.val_a = rf_rd.src_val;
          end
          data_move_pkg::K_IMM: begin
            // RULE_10 sign-extended immediate
            nxt_st.wr.we_a = 1'b1;
            nxt_st.wr.val_a = {{24{issue.opcode[7]}}, issue.opcode[7:0]};
          end
          data_move_pkg::K_LOAD, data_move_pkg::K_LITW, data_move_pkg::K_LITL: begin
            nxt_st.wr.we_a = 1'b1;
            nxt_st.wr.val_a = load_ext;
            // RULE_05 increment unless same register
            if (mode_postinc && (src_num != dst_num)) begin
              nxt_st.wr.we_b = 1'b1;
              nxt_st.wr.val_b = rf_rd.src_val + size_bytes;
            end
          end
          data_move_pkg::K_STORE: begin
            // RULE_04 pointer keeps decremented address
            if (mode_predec) begin
              nxt_st.wr.we_b = 1'b1;
              nxt_st.wr.val_b = addr;
            end
          end
          data_move_pkg::K_ILL: begin
            nxt_st.done = 1'b0;
          end
          default: begin
            nxt_st.done = 1'b0;
          end
        endcase
      end
    end
  end

  // Register state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rf_wr = st_ff.wr;
  assign next_pc = st_ff.npc;
  assign done = st_ff.done;
  assign addr_error = st_ff.err;
  assign error_addr = st_ff.eaddr;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_copy_value: assert property ( // RULE_01
    kind == data_move_pkg::K_COPY |=> rf_wr.we_a && rf_wr.val_a == $past(rf_rd.src_val))
    else $error("copy value wrong");
  chk_store_lanes: assert property ( // RULE_02
    mem_req.req && mem_req.wr && size == data_move_pkg::SZ_B |-> mem_req.wdata[31:8] == 24'h0)
    else $error("byte store upper lanes not zero");
  chk_byte_sign: assert property ( // RULE_03
    mem_req.req && !mem_req.wr && size == data_move_pkg::SZ_B |=> rf_wr.val_a[31:8] == {24{rf_wr.val_a[7]}})
    else $error("byte load not sign extended");
  chk_predec_ptr: assert property ( // RULE_04
    kind == data_move_pkg::K_STORE && mode_predec && !misaligned
      |-> addr == rf_rd.dst_val - size_bytes ##1 rf_wr.we_b && rf_wr.val_b == $past(addr))
    else $error("pre-decrement pointer wrong");
  chk_postinc_same: assert property ( // RULE_05
    mode_postinc && src_num == dst_num |=> !rf_wr.we_b)
    else $error("post-increment on same register");
  chk_index_addr: assert property ( // RULE_06
    kind == data_move_pkg::K_STORE && grp == data_move_pkg::OP_GRP_IDX
      |-> mem_req.addr == rf_rd.dst_val + rf_rd.idx_val)
    else $error("indexed store address wrong");
  chk_litl_align: assert property ( // RULE_12
    kind == data_move_pkg::K_LITL |-> mem_req.addr[1:0] == 2'h0)
    else $error("longword literal not aligned");
  chk_slot_base: assert property ( // RULE_14
    issue.valid && issue.delay_slot |-> lit_pc == issue.branch_pc + data_move_pkg::INSN_STEP)
    else $error("delay slot base wrong");
  chk_pc_step: assert property ( // RULE_17
    done |-> next_pc == $past(issue.pc) + data_move_pkg::INSN_STEP)
    else $error("pc step wrong");
  chk_misalign_err: assert property ( // RULE_18
    mem_kind && misaligned |-> !mem_req.req ##1 addr_error && !rf_wr.we_a)
    else $error("misaligned access not flagged");

  cov_postinc: cover property (mode_postinc && src_num != dst_num);
  cov_slot_lit: cover property (kind == data_move_pkg::K_LITL && issue.delay_slot);
  cov_err: cover property (addr_error);

endmodule

`default_nettype wire

// >>> rtl/data_move_pkg.sv
// Constants, opcode fields and carrier structs for the data-move unit.
// Assumes a single CPU clock domain and a simple one-cycle data bus.
//
// Behaviour
// RULE_01 - Register copy writes full source to destination
// RULE_02 - Stores support byte, word, longword sizes
// RULE_03 - Byte and word loads sign-extend to 32
// RULE_04 - Pre-decrement stores subtract size, write, keep address
// RULE_05 - Post-increment loads add size unless registers equal
// RULE_06 - Indexed stores address destination plus register zero
// RULE_07 - Indexed loads address source plus register zero
// RULE_08 - Indirect loads leave the pointer unchanged
// RULE_09 - Indirect stores leave both registers unchanged
// RULE_10 - Immediate load sign-extends eight-bit field
// RULE_11 - Word literal: displacement times two plus PC
// RULE_12 - Longword literal: times four, PC low bits cleared
// RULE_13 - Literal PC is second following instruction
// RULE_14 - In delay slot, PC is branch plus two
// RULE_15 - Literal reach limited to 510 or 1020 bytes
// RULE_16 - Software places literal tables within reach
// RULE_17 - One cycle per instruction, PC plus two
// RULE_18 - Misaligned word or longword raises address error
package data_move_pkg;

  // ****************************************
  // Widths and sizes
  // ****************************************
  localparam int unsigned DATA_W = 32;
  localparam logic [31:0] SIZE_BYTE = 32'h0000_0001;
  localparam logic [31:0] SIZE_WORD = 32'h0000_0002;
  localparam logic [31:0] SIZE_LONG = 32'h0000_0004;
  localparam logic [31:0] INSN_STEP = 32'h0000_0002;  // Opcode length in bytes
  localparam logic [31:0] LIT_PC_AHEAD = 32'h0000_0004;  // Second instruction after
  localparam logic [31:0] LONG_ALIGN_MASK = 32'hFFFF_FFFC;

  // ****************************************
  // Opcode major groups and minor codes
  // ****************************************
  localparam logic [3:0] OP_GRP_IDX = 4'h0;
  localparam logic [3:0] OP_GRP_STORE = 4'h2;
  localparam logic [3:0] OP_GRP_LOAD = 4'h6;
  localparam logic [3:0] OP_GRP_LITW = 4'h9;
  localparam logic [3:0] OP_GRP_LITL = 4'hD;
  localparam logic [3:0] OP_GRP_IMM = 4'hE;
  localparam logic [3:0] MINOR_COPY = 4'h3;

  // Access size code
  typedef enum logic [1:0] {
    SZ_B = 2'h0,
    SZ_W = 2'h1,
    SZ_L = 2'h2
  } size_e;

  // Decoded operation kind, one-hot
  typedef enum logic [7:0] {
    K_NONE = 8'h01,
    K_COPY = 8'h02,
    K_IMM = 8'h04,
    K_STORE = 8'h08,
    K_LOAD = 8'h10,
    K_LITW = 8'h20,
    K_LITL = 8'h40,
    K_ILL = 8'h80
  } kind_e;

  // Instruction issue request
  typedef struct packed {
    logic valid;
    logic [15:0] opcode;
    logic [31:0] pc;          // Address of this instruction
    logic delay_slot;         // Sits after a delayed branch
    logic [31:0] branch_pc;   // Address of that branch
  } issue_s;

  // Register file read values
  typedef struct packed {
    logic [31:0] src_val;
    logic [31:0] dst_val;
    logic [31:0] idx_val;
  } rf_rd_s;

  // Memory access request
  typedef struct packed {
    logic req;
    logic wr;
    size_e size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_s;

  // Register file write ports
  typedef struct packed {
    logic we_a;
    logic [3:0] num_a;
    logic [31:0] val_a;
    logic we_b;
    logic [3:0] num_b;
    logic [31:0] val_b;
  } rf_wr_s;

endpackage
